// ==== src/ssr_map.svh ====
// Constants for the secured region host controller.
// Assumes a 16-bit word-wide asynchronous NOR flash on the far side.
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_UNLOCK1_OFF 24'h000555
`define SSR_UNLOCK2_OFF 24'h0002aa
`define SSR_UNLOCK1_DATA 16'h00aa
`define SSR_UNLOCK2_DATA 16'h0055
`define SSR_ENTRY_DATA 16'h0088
`define SSR_EXIT_DATA 16'h0090
`define SSR_PROG_DATA 16'h00a0
`define SSR_EXIT4_OFF 24'h000000
`define SSR_EXIT4_DATA 16'h0000
`define SSR_ID_OFF 24'h000003
`define SSR_FACT_LOCK_BIT 7
`define SSR_CUST_LOCK_BIT 6
`define SSR_REGION_WORDS 256
`define SSR_CUST_BASE 24'h000080
`define SSR_SETUP_NS 20
`define SSR_PULSE_NS 40
`define SSR_HOLD_NS 20
`define SSR_ACCESS_NS 80
`endif

// ==== src/ssr_pkg.sv ====
// Types for the secured region host controller.
// Assumes ssr_map.svh is on the include path.
package ssr_pkg;
   typedef enum logic [2:0] {
      SSR_OP_READ = 3'h0,
      SSR_OP_ENTER = 3'h1,
      SSR_OP_EXIT = 3'h2,
      SSR_OP_PROG = 3'h3,
      SSR_OP_LOCKS = 3'h4
   } ssr_op_t;
   typedef struct packed {
      ssr_op_t op;
      logic [23:0] addr;
      logic [15:0] data;
   } ssr_req_t;
   typedef struct packed {
      logic [23:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [15:0] dq_o;
      logic dq_oe_n;
      logic rst_n;
   } ssr_pins_t;
endpackage

// ==== src/ssr_host.sv ====
// Host-side controller that drives a NOR flash through its bus pins
// to enter, read, program and leave the secured region.
// Assumes one 250 MHz clock and flash inputs synchronous to it.
// Summary of operation
// - Entry is AA, 55, 88 unlock writes
// - Exit is AA, 55, 90, then zero
// - Program is AA, 55, A0, then data
// - Host stays in mode until an exit request or a reset
`include "ssr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ssr_host
#(parameter int CLK_MHZ = 250)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire ssr_pkg::ssr_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic rsp_refused_o,
   output logic in_mode_o,
   output logic fact_locked_o,
   output logic cust_locked_o,
   input wire logic dev_busy_i,
   input wire logic [15:0] dq_i,
   output ssr_pkg::ssr_pins_t pins_o
);
   import ssr_pkg::*;
   localparam int SETUP_CYC = (`SSR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC = (`SSR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (`SSR_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int ACCESS_CYC = (`SSR_ACCESS_NS * CLK_MHZ + 999) / 1000;
   // The phase counter is eight bits, so a slow strobe at a fast clock cannot be served
   if (CLK_MHZ < 1 || ACCESS_CYC > 255)
   begin : g_bad_clock
      $error("ssr_host: clock rate not served");
   end
   // Gray-coded along set-up, strobe, hold
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD = 3'b010,
      ST_DONE = 3'b110
   } ssr_state_t;
   ssr_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [1:0] step_reg, step_next, last_reg, last_next;
   ssr_req_t cur_reg, cur_next;
   logic mode_reg, mode_next, fact_reg, fact_next, cust_reg, cust_next;
   logic [15:0] rdata_reg, rdata_next;
   logic refused_reg, refused_next, rsp_reg, rsp_next, is_read;
   logic [23:0] cyc_addr;
   logic [15:0] cyc_data;
   assign is_read = (cur_reg.op == SSR_OP_READ) || (cur_reg.op == SSR_OP_LOCKS);
   // Address and data of the current bus cycle in the sequence
   always_comb
   begin
      cyc_addr = cur_reg.addr;
      cyc_data = cur_reg.data;
      if (cur_reg.op == SSR_OP_LOCKS)
         cyc_addr = `SSR_ID_OFF;
      else if (!is_read)
         case (step_reg)
            2'd0:
               {cyc_addr, cyc_data} = {`SSR_UNLOCK1_OFF, `SSR_UNLOCK1_DATA};
            2'd1:
               {cyc_addr, cyc_data} = {`SSR_UNLOCK2_OFF, `SSR_UNLOCK2_DATA};
            2'd2:
            begin
               cyc_addr = `SSR_UNLOCK1_OFF;
               cyc_data = (cur_reg.op == SSR_OP_ENTER) ? `SSR_ENTRY_DATA :
                  (cur_reg.op == SSR_OP_EXIT) ? `SSR_EXIT_DATA : `SSR_PROG_DATA;
            end
            default:
               if (cur_reg.op == SSR_OP_EXIT)
                  {cyc_addr, cyc_data} = {`SSR_EXIT4_OFF, `SSR_EXIT4_DATA};
         endcase
   end
   // Sequencer: takes a request, then runs each bus cycle through set-up, strobe and hold.
   // Refusals are decided before chip select falls, so no half-written unlock reaches the bus.
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg - 8'h01; // Every phase reloads it, so a wrap while idle is harmless
      step_next = step_reg;
      last_next = last_reg;
      cur_next = cur_reg;
      mode_next = mode_reg;
      fact_next = fact_reg;
      cust_next = cust_reg;
      rdata_next = rdata_reg;
      refused_next = refused_reg;
      rsp_next = (state_reg == ST_DONE);
      case (state_reg)
         ST_IDLE:
         begin
            if (req_valid_i)
            begin
               cur_next = req_i;
               step_next = 2'd0;
               refused_next = 1'b0;
               cnt_next = 8'(SETUP_CYC);
               state_next = ST_SETUP;
               last_next = (req_i.op == SSR_OP_EXIT) ? 2'd3 :
                  (req_i.op == SSR_OP_PROG) ? 2'd3 :
                  (req_i.op == SSR_OP_ENTER) ? 2'd2 : 2'd0;
               // Every request but SSR_OP_READ, lock reads included, is refused at once while the array is busy
               if (dev_busy_i && req_i.op != SSR_OP_READ)
               begin
                  refused_next = 1'b1;
                  state_next = ST_DONE;
               end
               // Program only inside the mode, only to an open customer half
               else if (req_i.op == SSR_OP_PROG && (!mode_reg || cust_reg ||
                        req_i.addr[23:8] != 16'h0000 || req_i.addr < `SSR_CUST_BASE))
               begin
                  refused_next = 1'b1;
                  state_next = ST_DONE;
               end
               else if (req_i.op == SSR_OP_ENTER && mode_reg)
                  state_next = ST_DONE; // Already in the mode
               else if (req_i.op == SSR_OP_EXIT && !mode_reg)
                  state_next = ST_DONE; // Nothing to leave
            end
         end
         ST_SETUP:
         begin
            if (cnt_reg <= 8'h01)
            begin
               cnt_next = is_read ? 8'(ACCESS_CYC) : 8'(PULSE_CYC);
               state_next = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            if (cnt_reg <= 8'h01)
            begin
               if (is_read)
               begin
                  rdata_next = dq_i;
                  if (cur_reg.op == SSR_OP_LOCKS)
                  begin
                     fact_next = dq_i[`SSR_FACT_LOCK_BIT];
                     cust_next = dq_i[`SSR_CUST_LOCK_BIT];
                  end
               end
               cnt_next = 8'(HOLD_CYC);
               state_next = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            if (cnt_reg <= 8'h01)
            begin
               if (step_reg == last_reg)
               begin
                  if (cur_reg.op == SSR_OP_ENTER)
                     mode_next = 1'b1;
                  else if (cur_reg.op == SSR_OP_EXIT)
                     mode_next = 1'b0;
                  state_next = ST_DONE;
               end
               else
               begin
                  step_next = step_reg + 2'd1;
                  cnt_next = 8'(SETUP_CYC);
                  state_next = ST_SETUP;
               end
            end
         end
         ST_DONE:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end
   // Registers only; a reset also pulses the flash reset pin, so the
   // device falls back to the normal array and the mode flag is cleared
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         step_reg <= 2'd0;
         last_reg <= 2'd0;
         cur_reg <= '0;
         mode_reg <= 1'b0;
         fact_reg <= 1'b1;
         cust_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         refused_reg <= 1'b0;
         rsp_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         step_reg <= step_next;
         last_reg <= last_next;
         cur_reg <= cur_next;
         mode_reg <= mode_next;
         fact_reg <= fact_next;
         cust_reg <= cust_next;
         rdata_reg <= rdata_next;
         refused_reg <= refused_next;
         rsp_reg <= rsp_next;
      end
   end
   // Pin drive; reads of first-sector addresses hit the region in mode
   always_comb
   begin
      pins_o.addr = cyc_addr;
      pins_o.ce_n = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
      pins_o.oe_n = !(is_read && state_reg == ST_STROBE);
      pins_o.we_n = !(!is_read && state_reg == ST_STROBE);
      pins_o.dq_o = cyc_data;
      pins_o.dq_oe_n = is_read || pins_o.ce_n;
      pins_o.rst_n = !rst_i;
   end
   assign req_ready_o = (state_reg == ST_IDLE);
   assign rsp_valid_o = rsp_reg;
   assign rsp_data_o = rdata_reg;
   assign rsp_refused_o = refused_reg;
   assign in_mode_o = mode_reg;
   assign fact_locked_o = fact_reg;
   assign cust_locked_o = cust_reg;
   property p_no_prog_locked;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_IDLE && req_valid_i && req_i.op == SSR_OP_PROG && cust_reg)
      |=> state_reg == ST_DONE ##1 (rsp_valid_o && rsp_refused_o);
   endproperty
   a_no_prog_locked: assert property (p_no_prog_locked) else $error("program to locked half ran");
   property p_busy_refused;
      @(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_IDLE && req_valid_i && dev_busy_i && req_i.op != SSR_OP_READ)
      |=> ##1 rsp_refused_o;
   endproperty
   a_busy_refused: assert property (p_busy_refused) else $error("busy request not refused");
   property p_unlock1;
      @(posedge clk_i) disable iff (rst_i)
      (!pins_o.we_n && step_reg == 2'd0) |-> (pins_o.addr == `SSR_UNLOCK1_OFF &&
      pins_o.dq_o == `SSR_UNLOCK1_DATA);
   endproperty
   a_unlock1: assert property (p_unlock1) else $error("bad first unlock cycle");
   property p_exit_cmd;
      @(posedge clk_i) disable iff (rst_i)
      (!pins_o.we_n && step_reg == 2'd2 && cur_reg.op == SSR_OP_EXIT)
      |-> pins_o.dq_o == `SSR_EXIT_DATA && pins_o.addr == `SSR_UNLOCK1_OFF;
   endproperty
   a_exit_cmd: assert property (p_exit_cmd) else $error("bad exit command");
   property p_prog_cmd;
      @(posedge clk_i) disable iff (rst_i)
      (!pins_o.we_n && step_reg == 2'd2 && cur_reg.op == SSR_OP_PROG)
      |-> pins_o.dq_o == `SSR_PROG_DATA;
   endproperty
   a_prog_cmd: assert property (p_prog_cmd) else $error("bad program setup");
   property p_mode_hold;
      @(posedge clk_i) disable iff (rst_i)
      $fell(mode_reg) |-> $past(cur_reg.op) == SSR_OP_EXIT;
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode left without exit");
   property p_reset_mode;
      @(posedge clk_i) rst_i |-> !pins_o.rst_n ##1 !in_mode_o;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("mode kept over reset");
   property p_id_addr;
      @(posedge clk_i) disable iff (rst_i)
      (!pins_o.oe_n && cur_reg.op == SSR_OP_LOCKS) |-> pins_o.addr == `SSR_ID_OFF;
   endproperty
   a_id_addr: assert property (p_id_addr) else $error("lock read at wrong address");
   c_enter: cover property (@(posedge clk_i) $rose(mode_reg));
   c_exit: cover property (@(posedge clk_i) $fell(mode_reg));
   c_prog: cover property (@(posedge clk_i) !pins_o.we_n && step_reg == 2'd3);
   c_refuse: cover property (@(posedge clk_i) rsp_valid_o && rsp_refused_o);
endmodule // ssr_host
`default_nettype wire

// ==== test/ssr_flash_model.sv ====
// Behavioural NOR flash with a secured region, seen through the host pins.
// Assumes the host changes its pins only on rising edges of clk_i.
`include "ssr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ssr_flash_model
#(
   parameter logic [23:0] SECT_WORDS = 24'h008000
)
(
   input wire logic clk_i,
   input wire ssr_pkg::ssr_pins_t pins_i,
   input wire logic lock_cust_i,
   output logic [15:0] dq_o
);
   import ssr_pkg::*;
   logic mode_reg;
   logic cust_lock_reg;
   logic pend_reg;
   logic [2:0] seq_reg;
   logic [23:0] wa_reg;
   logic [15:0] wd_reg;
   logic [15:0] last_reg;
   logic [15:0] rd_val;
   logic [15:0] mem [0:255];
   logic [23:0] a;
   assign a = pins_i.addr;
   // Factory half holds a serial, customer half is erased
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = (i < 128) ? 16'h1000 + 16'(i) : 16'hffff;
      cust_lock_reg = 1'b0;
      mode_reg = 1'b0;
      seq_reg = 3'h0;
      pend_reg = 1'b0;
      last_reg = 16'h0000;
   end
   // Once set the customer lock never clears, not even on reset
   always @(posedge lock_cust_i) cust_lock_reg <= 1'b1;
   // Command decoder: a write takes effect when its strobe ends
   always @(posedge clk_i)
   begin
      if (!pins_i.rst_n)
      begin
         mode_reg <= 1'b0;
         seq_reg <= 3'h0;
         pend_reg <= 1'b0;
      end
      else if (!pins_i.we_n && !pins_i.ce_n)
      begin
         wa_reg <= a;
         wd_reg <= pins_i.dq_oe_n ? ~pins_i.dq_o : pins_i.dq_o; // An undriven bus reads as noise
         pend_reg <= 1'b1;
      end
      else if (pend_reg)
      begin
         pend_reg <= 1'b0;
         seq_reg <= 3'h0;
         case (seq_reg)
            3'h0: if (wa_reg == `SSR_UNLOCK1_OFF && wd_reg == `SSR_UNLOCK1_DATA) seq_reg <= 3'h1;
            3'h1: if (wa_reg == `SSR_UNLOCK2_OFF && wd_reg == `SSR_UNLOCK2_DATA) seq_reg <= 3'h2;
            3'h2: if (wa_reg == `SSR_UNLOCK1_OFF)
            begin
               if (wd_reg == `SSR_ENTRY_DATA) mode_reg <= 1'b1;
               if (wd_reg == `SSR_EXIT_DATA) mode_reg <= 1'b0;
               if (wd_reg == `SSR_PROG_DATA) seq_reg <= 3'h4;
            end
            3'h4: if (mode_reg && wa_reg[23:7] == 17'h00001 && !cust_lock_reg)
               mem[wa_reg[7:0]] <= mem[wa_reg[7:0]] & wd_reg;
            default: seq_reg <= 3'h0;
         endcase
      end
   end
   // Read path: region overlays the first sector while in the mode
   always_comb
   begin
      if (a == `SSR_ID_OFF && !mode_reg)
         rd_val = {8'h00, 1'b1, cust_lock_reg, 6'h00};
      else if (mode_reg && a < SECT_WORDS)
         rd_val = (a < 24'h000100) ? mem[a[7:0]] : ~last_reg;
      else
         rd_val = a[15:0] ^ 16'h5a5a;
   end
   // Released bus shows the inverse of the last word, never a stale copy
   assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd_val : ~last_reg;
   always @(posedge clk_i) if (!pins_i.ce_n && !pins_i.oe_n) last_reg <= rd_val;
endmodule // ssr_flash_model
`default_nettype wire

// ==== test/test_secured_region_access_logic.sv ====
// Self-checking bench for the secured region host controller.
// Assumes the flash model answers on dq and the bench drives the device busy line.
`include "ssr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module test_secured_region_access_logic;
   import ssr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   ssr_req_t req_i = '0;
   logic dev_busy_i = 1'b0;
   logic lock_cust = 1'b0;
   logic req_ready_o, rsp_valid_o, rsp_refused_o, in_mode_o, fact_locked_o, cust_locked_o;
   logic [15:0] rsp_data_o, dq_i, got;
   ssr_pins_t pins_o;
   int bad_count = 0, comparisons = 0, wr_cnt = 0;
   ssr_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .rsp_refused_o(rsp_refused_o), .in_mode_o(in_mode_o), .fact_locked_o(fact_locked_o),
      .cust_locked_o(cust_locked_o), .dev_busy_i(dev_busy_i), .dq_i(dq_i), .pins_o(pins_o));
   ssr_flash_model flash (.clk_i(clk_i), .pins_i(pins_o), .lock_cust_i(lock_cust), .dq_o(dq_i));
   // 250 MHz clock
   always #2 clk_i = ~clk_i;
   // Count write strobes to judge sequence lengths
   always @(negedge pins_o.we_n) wr_cnt++;
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One request: wait for ready, present for one edge, wait for the answer
   task automatic req(input ssr_op_t op, input logic [23:0] ad, input logic [15:0] da);
      int n = 0;
      @(negedge clk_i);
      while (req_ready_o !== 1'b1 && n < 100)
      begin
         @(negedge clk_i);
         n++;
      end
      wr_cnt = 0;
      req_i = '{op, ad, da};
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      check("answer", 16'h0001, {15'h0, rsp_valid_o});
      got = rsp_data_o;
   endtask
   task automatic reset_dut();
      rst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check("reset pin", 16'h0000, {15'h0, pins_o.rst_n});
      rst_i = 1'b0;
      @(negedge clk_i);
      check("mode after reset", 16'h0000, {15'h0, in_mode_o});
      check("chip select idle", 16'h0001, {15'h0, pins_o.ce_n});
   endtask
   task automatic t_boot();
      req(SSR_OP_LOCKS, `SSR_ID_OFF, 16'h0000);
      check("factory lock", 16'h0001, {15'h0, fact_locked_o});
      check("customer lock", 16'h0000, {15'h0, cust_locked_o});
      check("lock word", 16'h0080, got);
      req(SSR_OP_READ, 24'h000010, 16'h0000);
      check("array word", 16'h5a4a, got);
      req(SSR_OP_PROG, 24'h000085, 16'h1234);
      check("prog out of mode", 16'h0001, {15'h0, rsp_refused_o});
      check("no writes", 16'h0000, 16'(wr_cnt));
      $display("boot test done");
   endtask
   task automatic t_enter();
      req(SSR_OP_ENTER, 24'h000000, 16'h0000);
      check("entry writes", 16'h0003, 16'(wr_cnt));
      check("in mode", 16'h0001, {15'h0, in_mode_o});
      req(SSR_OP_READ, 24'h000007, 16'h0000);
      check("serial word", 16'h1007, got);
      req(SSR_OP_READ, 24'h000085, 16'h0000);
      check("customer word", 16'hffff, got);
      req(SSR_OP_READ, 24'h009000, 16'h0000);
      check("outside sector", 16'hca5a, got);
      req(SSR_OP_ENTER, 24'h000000, 16'h0000);
      check("repeat entry", 16'h0000, 16'(wr_cnt));
      check("still in mode", 16'h0001, {15'h0, in_mode_o});
      $display("entry test done");
   endtask
   task automatic t_prog();
      req(SSR_OP_PROG, 24'h000085, 16'h1234);
      check("prog accepted", 16'h0000, {15'h0, rsp_refused_o});
      check("prog writes", 16'h0004, 16'(wr_cnt));
      req(SSR_OP_READ, 24'h000085, 16'h0000);
      check("prog readback", 16'h1234, got);
      req(SSR_OP_PROG, 24'h000010, 16'h0000);
      check("factory refused", 16'h0001, {15'h0, rsp_refused_o});
      req(SSR_OP_PROG, 24'h000100, 16'h0000);
      check("beyond region", 16'h0001, {15'h0, rsp_refused_o});
      dev_busy_i = 1'b1;
      req(SSR_OP_PROG, 24'h000086, 16'h0000);
      check("busy refused", 16'h0001, {15'h0, rsp_refused_o});
      check("busy no writes", 16'h0000, 16'(wr_cnt));
      dev_busy_i = 1'b0;
      $display("program test done");
   endtask
   task automatic t_exit_lock();
      req(SSR_OP_EXIT, 24'h000000, 16'h0000);
      check("exit writes", 16'h0004, 16'(wr_cnt));
      check("out of mode", 16'h0000, {15'h0, in_mode_o});
      req(SSR_OP_READ, 24'h000000, 16'h0000);
      check("array back", 16'h5a5a, got);
      lock_cust = 1'b1;
      req(SSR_OP_LOCKS, `SSR_ID_OFF, 16'h0000);
      check("customer locked", 16'h0001, {15'h0, cust_locked_o});
      check("locked lock word", 16'h00c0, got);
      req(SSR_OP_ENTER, 24'h000000, 16'h0000);
      req(SSR_OP_PROG, 24'h000086, 16'h0000);
      check("locked refused", 16'h0001, {15'h0, rsp_refused_o});
      req(SSR_OP_READ, 24'h000086, 16'h0000);
      check("locked word", 16'hffff, got);
      reset_dut();
      req(SSR_OP_READ, 24'h000000, 16'h0000);
      check("array after reset", 16'h5a5a, got);
      $display("exit and lock test done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      reset_dut();
      t_boot();
      t_enter();
      t_prog();
      t_exit_lock();
      tally_and_finish();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #(50000 * 4);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      tally_and_finish();
   end
endmodule // test_secured_region_access_logic
`default_nettype wire
